// ==== src/tsm_params.svh ====
// constants for the ternary search match core
// assumes a single clk domain at the double rate; included by the package
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH
`define TSM_KEY_W       68
`define TSM_DEPTH       16
`define TSM_IDX_W       4
`define TSM_PARAM_W     7
`define TSM_SADR_W      22
`define TSM_ID_W        5
// pipeline stages added after arbitration, counted in internal clk cycles
`define TSM_PIPE_LAT    3
// command parameter fields
`define TSM_P_SEL_MASK  0
`define TSM_P_ADDR_LO   1
`define TSM_P_SRAM      5
`define TSM_OP_READ     2'b00
`define TSM_OP_WRITE    2'b01
`define TSM_OP_SEARCH   2'b10
`define TSM_OP_ENTRY_A  2'b11
`endif

// ==== src/tsm_pkg.sv ====
// types shared by the ternary search match core and its bench
// assumes tsm_params.svh is on the include path
`include "tsm_params.svh"
package tsm_pkg;
   typedef enum logic [1:0] {
      OP_PROG_READ  = `TSM_OP_READ,
      OP_PROG_WRITE = `TSM_OP_WRITE,
      OP_SEARCH     = `TSM_OP_SEARCH,
      OP_ENTRY_A    = `TSM_OP_ENTRY_A
   } op_t;
   typedef struct packed {
      logic [`TSM_PARAM_W-1:0] param;
      op_t                     op;
   } cmd_t;
   typedef struct packed {
      logic                  valid;
      logic                  hit;
      logic [`TSM_IDX_W-1:0] idx;
   } result_t;
endpackage

// ==== src/ternary_search_match_core.sv ====
// search core of a cascadable ternary match engine: table, priority encoder,
// cascade arbitration and result pipeline toward the associated-data sram.
// assumes clk is the double rate clock, inputs synchronous to it, and the
// host holding command and key for one whole internal (half-rate) cycle.
//
// Behaviour
// - command code and parameter arrive together on the nine-bit command bus and are decoded.
// - the 68-bit key/data bus carries the key on a search and the data on reads and writes.
// - on a flow-through sram access the key/data bus carries the sram address and it is passed on.
// - each entry holds data and mask, and a masked bit is don't-care while others must equal.
// - among several matching entries the lowest address is reported.
// - on a search only the cascade-wide lowest-address winner drives the sram bus, the others stay off.
// - search sram cycles and the hit flag with its valid are delayed to let arbitration finish; flow-through sram cycles leave on the next tick.
// - the two low command bits select read, write, search or entry_a, the upper seven are parameters.
// - the command bus is ignored while command_valid is low.
// - the hit flag rises only for the global winner and a separate valid qualifies it.
// - inputs are sampled on rising clk and the half-rate phase comes from phase_select_n.
`timescale 1ns/1ns
`default_nettype none
`include "tsm_params.svh"

module ternary_search_match_core (
   input  wire logic                    clk,            // double rate clock
   input  wire logic                    nrst,           // async reset, low
   input  wire logic                    phase_select_n, // low marks internal edge
   input  wire logic                    command_valid,  // command qualifier
   input  wire tsm_pkg::cmd_t           cmd,            // command bus
   input  wire logic [`TSM_KEY_W-1:0]   dq_in,          // key/data in
   input  wire logic [`TSM_ID_W-1:0]    device_id,      // cascade position
   input  wire logic                    cascade_hit_in, // upstream device hit
   output logic                         local_hit_out,  // own hit to cascade
   output logic [`TSM_KEY_W-1:0]        dq_out,         // read data
   output logic                         dq_oe,          // dq driven
   output logic                         read_ack,       // read data valid
   output logic                         search_hit_flag,  // global winner
   output logic                         search_hit_valid, // flag qualifier
   output logic [`TSM_SADR_W-1:0]       sram_addr,      // sram address
   output logic                         sram_oe,        // sram bus driven
   output logic                         sram_ce_n,      // sram chip enable
   output logic                         sram_we_n       // sram write enable
);
   import tsm_pkg::*;

   // ----------------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------------
   // internal clk edge: only cycles with phase low advance the core
   logic tick;
   logic take;
   logic is_read;
   logic is_write;
   logic is_search;
   logic is_sram;
   logic sel_mask;
   logic [`TSM_IDX_W-1:0] acc_idx;
   logic tbl_wr_data;
   logic tbl_wr_mask;
   logic tbl_rd;
   logic sram_wr;
   logic sram_rd;
   // every access below is qualified by take, so idle ticks do nothing
   assign tick      = ~phase_select_n;
   assign take      = tick & command_valid;
   assign is_read   = take & (cmd.op == OP_PROG_READ);
   assign is_write  = take & (cmd.op == OP_PROG_WRITE);
   assign is_search = take & (cmd.op == OP_SEARCH);
   assign is_sram   = cmd.param[`TSM_P_SRAM];
   assign sel_mask  = cmd.param[`TSM_P_SEL_MASK];
   assign acc_idx   = cmd.param[`TSM_P_ADDR_LO +: `TSM_IDX_W];

   // the flow-through bit steers an access away from the table to the sram;
   // a flow-through write never touches the arrays
   assign tbl_wr_data = is_write & ~is_sram & ~sel_mask;
   assign tbl_wr_mask = is_write & ~is_sram & sel_mask;
   assign tbl_rd      = is_read & ~is_sram;
   assign sram_wr     = is_write & is_sram;
   assign sram_rd     = is_read & is_sram;

   // ----------------------------------------------------------------------
   // data and mask arrays
   // ----------------------------------------------------------------------
   logic [`TSM_KEY_W-1:0] data_mem [`TSM_DEPTH];
   logic [`TSM_KEY_W-1:0] mask_mem [`TSM_DEPTH];
   logic [`TSM_DEPTH-1:0] match;

   // array writes need no reset; contents are undefined until loaded
   always_ff @(posedge clk) begin
      if (tbl_wr_data) begin
         data_mem[acc_idx] <= dq_in;
      end
      if (tbl_wr_mask) begin
         mask_mem[acc_idx] <= dq_in;
      end
   end

   // per entry compare: mask bit set means don't care
   // an unloaded entry holds unknowns, so the host loads the table first
   genvar g;
   generate
      for (g = 0; g < `TSM_DEPTH; g++) begin : g_cmp
         assign match[g] = ~|((dq_in ^ data_mem[g]) & ~mask_mem[g]);
      end
   endgenerate

   // ----------------------------------------------------------------------
   // priority encoder
   // ----------------------------------------------------------------------
   logic                  any_match;
   logic [`TSM_IDX_W-1:0] win_idx;
   // scan downward so the last assignment is the lowest index
   always_comb begin
      win_idx = '0;
      for (int i = `TSM_DEPTH - 1; i >= 0; i--) begin
         if (match[i]) begin
            win_idx = i[`TSM_IDX_W-1:0];
         end
      end
   end
   // a miss still travels down the pipe as a valid result with hit low
   assign any_match = |match;

   // ----------------------------------------------------------------------
   // search and arbitration stages
   // ----------------------------------------------------------------------
   result_t srch_q;
   result_t srch_d;
   result_t arb_d;
   assign srch_d = is_search ? result_t'{valid: 1'b1, hit: any_match, idx: win_idx}
                             : result_t'{valid: 1'b0, hit: 1'b0, idx: '0};
   // an upstream hit means a lower cascade address already wins
   assign arb_d  = '{valid: srch_q.valid,
                     hit:   srch_q.hit & ~cascade_hit_in,
                     idx:   srch_q.idx};

   // own hit leaves a tick ahead so downstream devices can arbitrate
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         srch_q        <= '0;
         local_hit_out <= 1'b0;
      end else if (tick) begin
         srch_q        <= srch_d;
         local_hit_out <= srch_d.valid & srch_d.hit;
      end
   end

   // ----------------------------------------------------------------------
   // result pipeline
   // ----------------------------------------------------------------------
   // fixed depth so every device in the cascade lands on the same cycle
   // a search may enter on every tick; results leave in the order taken
   result_t pipe_q [`TSM_PIPE_LAT];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < `TSM_PIPE_LAT; i++) begin
            pipe_q[i] <= '0;
         end
      end else if (tick) begin
         pipe_q[0] <= arb_d;
         for (int i = 1; i < `TSM_PIPE_LAT; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   result_t res;
   logic    pio_sram;
   logic    drive_sram;
   logic [`TSM_SADR_W-1:0] win_addr;
   assign res        = pipe_q[`TSM_PIPE_LAT-1];
   assign pio_sram   = sram_rd | sram_wr;
   assign drive_sram = (res.valid & res.hit) | pio_sram;
   // device id on top keeps the sram windows of cascaded devices apart;
   // the bits between id and index stay zero with this table depth
   assign win_addr   = {device_id, {(`TSM_SADR_W-`TSM_ID_W-`TSM_IDX_W){1'b0}}, res.idx};

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // flow-through access overrides a search result landing the same edge;
   // the host must not schedule both together
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         search_hit_flag  <= 1'b0;
         search_hit_valid <= 1'b0;
         sram_addr        <= '0;
         sram_oe          <= 1'b0;
         sram_ce_n        <= 1'b1;
         sram_we_n        <= 1'b1;
      end else if (tick) begin
         search_hit_flag  <= res.valid & res.hit;
         search_hit_valid <= res.valid;
         sram_oe          <= drive_sram;
         sram_ce_n        <= ~drive_sram;
         sram_we_n        <= ~sram_wr;
         if (pio_sram) begin
            sram_addr <= dq_in[`TSM_SADR_W-1:0];
         end else if (res.valid & res.hit) begin
            sram_addr <= win_addr;
         end
      end
   end

   // programmed read of the table, answered one internal cycle later
   // dq_oe marks the ticks in which the host must leave the bus alone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dq_out   <= '0;
         dq_oe    <= 1'b0;
         read_ack <= 1'b0;
      end else if (tick) begin
         dq_oe    <= tbl_rd;
         read_ack <= tbl_rd;
         if (tbl_rd) begin
            dq_out <= sel_mask ? mask_mem[acc_idx] : data_mem[acc_idx];
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/tsm_checker.sv ====
// port assertions for the search core
// assumes phase flips every clk and inputs move between ticks
`timescale 1ns/1ns
`default_nettype none
module tsm_checker (
   input wire logic          clk,              // clock
   input wire logic          nrst,             // reset
   input wire logic          phase_select_n,   // tick mark
   input wire logic          command_valid,    // qualifier
   input wire tsm_pkg::cmd_t cmd,              // command
   input wire logic [67:0]   dq_in,            // key
   input wire logic [4:0]    device_id,        // position
   input wire logic          read_ack,         // read done
   input wire logic          dq_oe,            // dq drive
   input wire logic          search_hit_flag,  // winner
   input wire logic          search_hit_valid, // qualifier
   input wire logic [21:0]   sram_addr,        // address
   input wire logic          sram_oe,          // sram drive
   input wire logic          sram_ce_n,        // enable
   input wire logic          sram_we_n         // write
);
   import tsm_pkg::*;
   // commands only count on ticks
   wire logic take = !phase_select_n && command_valid;
   wire logic srch = take && cmd.op == OP_SEARCH;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_srch; srch; endsequence
   sequence s_res; ##9 search_hit_valid; endsequence
   property p_lat; s_srch |-> s_res; endproperty
   a_lat: assert property (p_lat)
      else $error("search result late");
   property p_fix; search_hit_valid |-> $past(srch, 9) || $past(srch, 10); endproperty
   a_fix: assert property (p_fix)
      else $error("result without matching search");
   property p_win;
      search_hit_flag |-> search_hit_valid && sram_oe && !sram_ce_n
         && sram_addr[21:17] == device_id;
   endproperty
   a_win: assert property (p_win)
      else $error("winner not driving sram");
   property p_miss; search_hit_valid && !search_hit_flag |-> !sram_oe; endproperty
   a_miss: assert property (p_miss)
      else $error("loser drives sram");
   property p_read; take && cmd.op == OP_PROG_READ && !cmd.param[5] |=> read_ack && dq_oe;
   endproperty
   a_read: assert property (p_read)
      else $error("read not answered");
   property p_idle; !phase_select_n && !command_valid |=> !read_ack; endproperty
   a_idle: assert property (p_idle)
      else $error("idle bus answered");
   property p_ea; take && cmd.op == OP_ENTRY_A |=> !read_ack && !dq_oe; endproperty
   a_ea: assert property (p_ea)
      else $error("entry_a not ignored");
   property p_hold;
      phase_select_n |=> $stable(search_hit_valid) && $stable(read_ack) && $stable(sram_addr);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output moved off tick");
   property p_flow;
      take && cmd.param[5] && !cmd.op[1] |=> !sram_ce_n && sram_addr == $past(dq_in[21:0])
         && sram_we_n == ($past(cmd.op) == OP_PROG_READ);
   endproperty
   a_flow: assert property (p_flow)
      else $error("flow-through address lost");
endmodule
bind ternary_search_match_core tsm_checker chk (.clk, .nrst, .phase_select_n,
   .command_valid, .cmd, .dq_in, .device_id, .read_ack, .dq_oe, .search_hit_flag,
   .search_hit_valid, .sram_addr, .sram_oe, .sram_ce_n, .sram_we_n);
`default_nettype wire

// ==== bench/tsm_upstream.sv ====
// upstream cascade engine: answers the shared search with its own hit
// assumes it sees the core's command bus on the same ticks
`timescale 1ns/1ns
`default_nettype none
module tsm_upstream (
   input  wire logic          clk,            // clock
   input  wire logic          phase_select_n, // tick mark
   input  wire logic          command_valid,  // qualifier
   input  wire tsm_pkg::cmd_t cmd,            // shared bus
   input  wire logic          arm,            // we match
   output logic               cascade_hit_in  // to core
);
   import tsm_pkg::*;
   logic live_q = 1'b0;
   logic hit_q  = 1'b0;
   logic junk_q = 1'b0;
   // hit is only good for one tick; elsewhere the wire wanders
   always @(posedge clk) begin
      junk_q <= ~junk_q;
      if (!phase_select_n) begin
         live_q <= command_valid && cmd.op == OP_SEARCH;
         hit_q  <= arm;
      end
   end
   assign cascade_hit_in = live_q ? hit_q : junk_q;
endmodule
`default_nettype wire

// ==== bench/ternary_search_match_core_tb_top.sv ====
// bench for the search core: load, search, read, flow-through
// assumes one upstream engine on the cascade wire
`timescale 1ns/1ns
`default_nettype none
module ternary_search_match_core_tb_top;
   import tsm_pkg::*;
   localparam logic [67:0] base_key = 68'ha_5a5a_5a5a_5a5a_5a50;
   logic clk = 1'b0, nrst = 1'b0, phase_select_n = 1'b1, command_valid = 1'b0, arm = 1'b0;
   cmd_t        cmd = '0;
   logic [67:0] dq_in = '0, dq_out;
   logic [21:0] sram_addr;
   logic cascade_hit_in, local_hit_out, dq_oe, read_ack, search_hit_flag, search_hit_valid;
   logic sram_oe, sram_ce_n, sram_we_n;
   int errors = 0, compares = 0;
   always #5 clk = ~clk;
   // falling-edge flip: a rising edge with phase low is a tick
   always @(negedge clk) phase_select_n <= ~phase_select_n;
   ternary_search_match_core uut (.clk, .nrst, .phase_select_n, .command_valid, .cmd,
      .dq_in, .device_id(5'h0b), .cascade_hit_in, .local_hit_out, .dq_out, .dq_oe,
      .read_ack, .search_hit_flag, .search_hit_valid, .sram_addr, .sram_oe, .sram_ce_n,
      .sram_we_n);
   tsm_upstream up (.clk, .phase_select_n, .command_valid, .cmd, .arm, .cascade_hit_in);
   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [67:0] got, input logic [67:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // present one command just before a tick
   task automatic go(input logic v, input op_t o, input logic [6:0] p, input logic [67:0] d);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (phase_select_n !== 1'b1 && n < 4);
      if (n == 4) begin
         errors++;
         wrap_up();
      end
      command_valid <= v;
      cmd <= '{param: p, op: o};
      dq_in <= d;
   endtask
   // result shows four ticks after the search tick
   task automatic srch(input logic [67:0] k, input logic u, input logic m, input logic h,
                       input logic [3:0] i);
      go(1'b1, OP_SEARCH, 7'h00, k);
      arm <= u;
      @(negedge clk);
      chk(local_hit_out, m);
      repeat (4) go(1'b0, OP_SEARCH, 7'h00, 68'h0);
      @(negedge clk);
      chk(search_hit_valid, 1'b1);
      chk(search_hit_flag, h);
      chk(sram_oe, h);
      chk(sram_ce_n, !h);
      if (h) chk(sram_addr, {5'h0b, 13'h0, i});
   endtask
   task automatic rd(input logic s, input logic [3:0] i, input logic [67:0] e);
      go(1'b1, OP_PROG_READ, {2'b00, i, s}, 68'h0);
      @(negedge clk);
      chk(read_ack, 1'b1);
      chk(dq_out, e);
   endtask
   task automatic quiet(input logic v, input op_t o);
      go(v, o, 7'h0a, 68'h0);
      @(negedge clk);
      chk(read_ack, 1'b0);
   endtask
   task automatic flow(input op_t o, input logic [21:0] a, input logic w);
      go(1'b1, o, 7'h20, {46'h0, a});
      @(negedge clk);
      chk(sram_addr, a);
      chk(sram_ce_n, 1'b0);
      chk(sram_we_n, w);
   endtask
   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      // entry 9 ignores its low nibble
      for (int i = 0; i < 16; i++) begin
         go(1'b1, OP_PROG_WRITE, {2'b00, i[3:0], 1'b0}, base_key | 68'(i));
         go(1'b1, OP_PROG_WRITE, {2'b00, i[3:0], 1'b1}, (i == 9) ? 68'hf : 68'h0);
      end
      srch(base_key | 68'h5, 1'b0, 1'b1, 1'b1, 4'h5);
      srch(base_key | 68'hc, 1'b0, 1'b1, 1'b1, 4'h9);
      srch(base_key ^ 68'h100, 1'b0, 1'b0, 1'b0, 4'h0);
      srch(base_key | 68'h1, 1'b1, 1'b1, 1'b0, 4'h0);
      rd(1'b0, 4'hc, base_key | 68'hc);
      rd(1'b1, 4'h9, 68'hf);
      quiet(1'b0, OP_PROG_READ);
      quiet(1'b1, OP_ENTRY_A);
      flow(OP_PROG_WRITE, 22'h2a5a5, 1'b0);
      flow(OP_PROG_READ, 22'h15a5a, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
